//--- include/set_pkg.sv
package set_pkg;
   // i2c target
   localparam logic [6:0] I2C_ADDR = 7'h49;
   // register offsets
   localparam logic [7:0] OFF_FUNC_EN = 8'h80;
   localparam logic [7:0] OFF_LIGHT_IT = 8'h81;
   localparam logic [7:0] OFF_PROX_SP = 8'h82;
   localparam logic [7:0] OFF_WAIT_P = 8'h83;
   // reset values
   localparam logic [7:0] RST_FUNC_EN = 8'h00;
   localparam logic [7:0] RST_LIGHT_IT = 8'h00;
   localparam logic [7:0] RST_PROX_SP = 8'h1F;
   localparam logic [7:0] RST_WAIT_P = 8'h00;
   // function enable bit positions
   localparam int BIT_POWER_ON = 0;
   localparam int BIT_LIGHT_EN = 1;
   localparam int BIT_PROX_EN = 2;
   localparam int BIT_WAIT_EN = 3;
   // timing
   localparam int CLK_KHZ = 50000;
   localparam real LIGHT_STEP_MS = 2.78;
   localparam int LIGHT_STEP_CYCLES = int'(LIGHT_STEP_MS * CLK_KHZ);
   localparam int PROX_STEP_US = 88;
   localparam int PROX_STEP_CYCLES = PROX_STEP_US * CLK_KHZ / 1000;
   localparam logic [3:0] LONG_WAIT_LAST = 4'hB;
   // light full scale
   localparam int LIGHT_COUNT_SHIFT = 10;
   localparam logic [7:0] FULL_SCALE_MIN_SETTING = 8'h3F;
   localparam logic [15:0] FULL_SCALE_MAX = 16'hFFFF;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } set_wr_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_LIGHT = 2'b01,
      PH_PROX = 2'b11,
      PH_WAIT = 2'b10
   } set_phase_t;

   typedef enum logic [2:0] {
      I2_IDLE = 3'b000,
      I2_ADDR = 3'b001,
      I2_AACK = 3'b011,
      I2_RX = 3'b010,
      I2_RXACK = 3'b110,
      I2_TX = 3'b111,
      I2_TXACK = 3'b101
   } set_i2c_st_t;
endpackage : set_pkg

//--- verilog/set_i2c_target.sv
`timescale 1ns/10ps
module set_i2c_target (
   input wire logic core_clk, // system clock
   input wire logic resetn, // sync reset, active low
   input wire logic scl_in, // bus clock pin level
   input wire logic sda_in, // bus data pin level
   output logic sda_oe, // high while pulling data low
   input wire logic [7:0] rd_data, // byte at the pointer
   output logic [7:0] reg_ptr, // register pointer
   output set_pkg::set_wr_t wr // register write pulse
);
   typedef struct packed {
      logic scl1, scl2, scl3, scl_f, scl_p;
      logic sda1, sda2, sda3, sda_f, sda_p;
      set_pkg::set_i2c_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic rw;
      logic first;
      logic [7:0] ptr;
      logic oe;
      set_pkg::set_wr_t wr;
   } set_i2c_state_t;

   set_i2c_state_t s, next_s;
   logic rise, fall, start, stop;

   assign rise = s.scl_f & ~s.scl_p;
   assign fall = ~s.scl_f & s.scl_p;
   assign start = s.scl_f & s.scl_p & s.sda_p & ~s.sda_f;
   assign stop = s.scl_f & s.scl_p & ~s.sda_p & s.sda_f;

   always_comb begin
      next_s = s;
      next_s.wr.valid = 1'b0;
      next_s.scl1 = scl_in;
      next_s.scl2 = s.scl1;
      next_s.scl3 = s.scl2;
      next_s.sda1 = sda_in;
      next_s.sda2 = s.sda1;
      next_s.sda3 = s.sda2;
      // a change counts once the two later stages agree
      if (s.scl2 == s.scl3) begin
         next_s.scl_f = s.scl3;
      end
      if (s.sda2 == s.sda3) begin
         next_s.sda_f = s.sda3;
      end
      next_s.scl_p = s.scl_f;
      next_s.sda_p = s.sda_f;
      if (start) begin
         next_s.st = set_pkg::I2_ADDR;
         next_s.cnt = 4'h0;
         next_s.oe = 1'b0;
      end else if (stop) begin
         next_s.st = set_pkg::I2_IDLE;
         next_s.oe = 1'b0;
      end else begin
         case (s.st)
            set_pkg::I2_ADDR, set_pkg::I2_RX: begin
               if (rise) begin
                  next_s.sh = {s.sh[6:0], s.sda_f};
                  next_s.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == 4'h8) begin
                  next_s.cnt = 4'h0;
                  if (s.st == set_pkg::I2_ADDR) begin
                     if (s.sh[7:1] == set_pkg::I2C_ADDR) begin
                        next_s.st = set_pkg::I2_AACK;
                        next_s.oe = 1'b1;
                        next_s.rw = s.sh[0];
                     end else begin
                        next_s.st = set_pkg::I2_IDLE;
                     end
                  end else begin
                     next_s.st = set_pkg::I2_RXACK;
                     next_s.oe = 1'b1;
                     next_s.first = 1'b0;
                     if (s.first) begin
                        next_s.ptr = s.sh;
                     end else begin
                        next_s.wr = '{1'b1, s.ptr, s.sh};
                        next_s.ptr = s.ptr + 8'h01;
                     end
                  end
               end
            end
            set_pkg::I2_AACK, set_pkg::I2_TXACK: begin
               if (rise && s.st == set_pkg::I2_TXACK && s.sda_f) begin
                  next_s.st = set_pkg::I2_IDLE;
               end else if (fall) begin
                  if (s.rw) begin
                     next_s.st = set_pkg::I2_TX;
                     next_s.tx = rd_data;
                     next_s.oe = ~rd_data[7];
                  end else begin
                     next_s.st = set_pkg::I2_RX;
                     next_s.first = 1'b1;
                     next_s.oe = 1'b0;
                  end
               end
            end
            set_pkg::I2_RXACK: begin
               if (fall) begin
                  next_s.st = set_pkg::I2_RX;
                  next_s.oe = 1'b0;
               end
            end
            set_pkg::I2_TX: begin
               if (rise) begin
                  next_s.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == 4'h8) begin
                  next_s.st = set_pkg::I2_TXACK;
                  next_s.cnt = 4'h0;
                  next_s.oe = 1'b0;
                  next_s.ptr = s.ptr + 8'h01;
               end else if (fall) begin
                  next_s.tx = {s.tx[6:0], 1'b0};
                  next_s.oe = ~s.tx[6];
               end
            end
            default: begin
               next_s.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s <= '{scl1: 1'b1, scl2: 1'b1, scl3: 1'b1, scl_f: 1'b1,
                scl_p: 1'b1, sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
                sda_f: 1'b1, sda_p: 1'b1, st: set_pkg::I2_IDLE,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign sda_oe = s.oe;
   assign reg_ptr = s.ptr;
   assign wr = s.wr;

   chk_ptr_step: assert property (@(posedge core_clk) disable iff (!resetn)
      s.wr.valid |-> s.ptr == s.wr.addr + 8'h01)
      else $error("pointer did not advance after a write");
   chk_addr_ack: assert property (@(posedge core_clk) disable iff (!resetn)
      s.st == set_pkg::I2_AACK |-> s.oe && s.sh[7:1] == set_pkg::I2C_ADDR)
      else $error("address acknowledge wrong");
   cov_reg_write: cover property (@(posedge core_clk) disable iff (!resetn)
      s.wr.valid);
endmodule : set_i2c_target

//--- verilog/set_timing.sv
`timescale 1ns/10ps
// Function
// - bit 3 enables wait between cycles
// - bit 2 enables proximity detection
// - bit 1 enables light measurement
// - bit 0 powers oscillator and converters
// - integration lasts setting plus one periods
// - integration down counter ends at zero
// - full scale 1024 per period, saturating
// - prox sample lasts setting plus one steps
// - wait down counter, times 12 when long
// - i2c target 0x49, auto-incrementing pointer
module set_timing #(
   parameter int LIGHT_TICK = set_pkg::LIGHT_STEP_CYCLES,
   parameter int PROX_TICK = set_pkg::PROX_STEP_CYCLES
) (
   input wire logic core_clk, // system clock
   input wire logic resetn, // sync reset, active low
   input wire logic scl_in, // bus clock pin
   input wire logic sda_in, // bus data pin input
   output logic sda_out, // bus data pin output, always low
   output logic sda_oe, // bus data output enable
   input wire logic long_wait_multiplier, // wait times twelve
   output logic osc_enable, // oscillator and converters on
   output logic light_active, // light integration running
   output logic prox_active, // proximity sample running
   output logic wait_active, // wait period running
   output logic light_done, // integration finished pulse
   output logic prox_done, // proximity sample finished pulse
   output logic wait_done, // wait finished pulse
   output logic [15:0] light_full_scale // max light count
);
   typedef struct packed {
      set_pkg::set_phase_t st;
      logic [17:0] pre;
      logic [7:0] cnt;
      logic [3:0] lw;
      logic lwm;
      logic [7:0] func_en;
      logic [7:0] light_it;
      logic [7:0] prox_sp;
      logic [7:0] wait_p;
      logic [15:0] full_scale;
      logic light_done;
      logic prox_done;
      logic wait_done;
   } set_tim_state_t;

   localparam set_tim_state_t RESET_STATE = '{
      st: set_pkg::PH_IDLE, func_en: set_pkg::RST_FUNC_EN,
      light_it: set_pkg::RST_LIGHT_IT, prox_sp: set_pkg::RST_PROX_SP,
      wait_p: set_pkg::RST_WAIT_P, default: '0};

   set_tim_state_t s, next_s;
   set_pkg::set_wr_t wr;
   logic [7:0] reg_ptr;
   logic [7:0] rd_data;
   logic power_on, light_en, prox_en, wait_en;
   logic tick;
   logic [17:0] tick_last;
   logic [18:0] fs_calc;
   set_pkg::set_phase_t after;

   ////////////////////////////////////////////////////////////////////
   set_i2c_target u_i2c (
      .core_clk(core_clk),
      .resetn(resetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe(sda_oe),
      .rd_data(rd_data),
      .reg_ptr(reg_ptr),
      .wr(wr)
   );
   assign sda_out = 1'b0;

   always_comb begin
      if (reg_ptr == set_pkg::OFF_FUNC_EN) begin
         rd_data = s.func_en;
      end else if (reg_ptr == set_pkg::OFF_LIGHT_IT) begin
         rd_data = s.light_it;
      end else if (reg_ptr == set_pkg::OFF_PROX_SP) begin
         rd_data = s.prox_sp;
      end else if (reg_ptr == set_pkg::OFF_WAIT_P) begin
         rd_data = s.wait_p;
      end else begin
         rd_data = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign power_on = s.func_en[set_pkg::BIT_POWER_ON];
   assign light_en = s.func_en[set_pkg::BIT_LIGHT_EN];
   assign prox_en = s.func_en[set_pkg::BIT_PROX_EN];
   assign wait_en = s.func_en[set_pkg::BIT_WAIT_EN];
   assign tick_last = (s.st == set_pkg::PH_PROX) ?
      18'(PROX_TICK - 1) : 18'(LIGHT_TICK - 1);
   assign tick = (s.pre == tick_last);
   // 1024 counts per period, less one
   assign fs_calc = {({1'b0, s.light_it} + 9'h001), 10'h000} - 19'h00001;

   // next enabled phase, order light, prox, wait
   function automatic set_pkg::set_phase_t follow(
      input set_pkg::set_phase_t cur, input logic le, input logic pe,
      input logic we);
      set_pkg::set_phase_t r;
      r = set_pkg::PH_IDLE;
      case (cur)
         set_pkg::PH_LIGHT: begin
            r = pe ? set_pkg::PH_PROX : we ? set_pkg::PH_WAIT :
                le ? set_pkg::PH_LIGHT : set_pkg::PH_IDLE;
         end
         set_pkg::PH_PROX: begin
            r = we ? set_pkg::PH_WAIT : le ? set_pkg::PH_LIGHT :
                pe ? set_pkg::PH_PROX : set_pkg::PH_IDLE;
         end
         default: begin
            r = le ? set_pkg::PH_LIGHT : pe ? set_pkg::PH_PROX :
                we ? set_pkg::PH_WAIT : set_pkg::PH_IDLE;
         end
      endcase
      return r;
   endfunction : follow

   assign after = follow(s.st, light_en, prox_en, wait_en);

   always_comb begin
      next_s = s;
      next_s.light_done = 1'b0;
      next_s.prox_done = 1'b0;
      next_s.wait_done = 1'b0;
      next_s.pre = tick ? 18'h00000 : s.pre + 18'h00001;
      if (s.light_it >= set_pkg::FULL_SCALE_MIN_SETTING) begin
         next_s.full_scale = set_pkg::FULL_SCALE_MAX;
      end else begin
         next_s.full_scale = fs_calc[15:0];
      end
      // phase end or idle: pick and load the next phase
      if (s.st == set_pkg::PH_IDLE || (tick && s.cnt == 8'h00 &&
          (s.st != set_pkg::PH_WAIT || !s.lwm ||
           s.lw == set_pkg::LONG_WAIT_LAST))) begin
         next_s.light_done = (s.st == set_pkg::PH_LIGHT);
         next_s.prox_done = (s.st == set_pkg::PH_PROX);
         next_s.wait_done = (s.st == set_pkg::PH_WAIT);
         next_s.st = after;
         next_s.pre = 18'h00000;
         next_s.lw = 4'h0;
         next_s.lwm = long_wait_multiplier;
         case (after)
            set_pkg::PH_LIGHT: next_s.cnt = s.light_it;
            set_pkg::PH_PROX: next_s.cnt = s.prox_sp;
            set_pkg::PH_WAIT: next_s.cnt = s.wait_p;
            default: next_s.cnt = 8'h00;
         endcase
      end else if (tick) begin
         if (s.st == set_pkg::PH_WAIT && s.lwm &&
             s.lw != set_pkg::LONG_WAIT_LAST) begin
            next_s.lw = s.lw + 4'h1;
         end else begin
            next_s.lw = 4'h0;
            next_s.cnt = s.cnt - 8'h01;
         end
      end
      if (!power_on) begin
         next_s.st = set_pkg::PH_IDLE;
         next_s.pre = 18'h00000;
         next_s.cnt = 8'h00;
         next_s.lw = 4'h0;
      end
      // host writes take effect from the next cycle
      if (wr.valid) begin
         if (wr.addr == set_pkg::OFF_FUNC_EN) begin
            next_s.func_en = wr.data;
         end else if (wr.addr == set_pkg::OFF_LIGHT_IT) begin
            next_s.light_it = wr.data;
         end else if (wr.addr == set_pkg::OFF_PROX_SP) begin
            next_s.prox_sp = wr.data;
         end else if (wr.addr == set_pkg::OFF_WAIT_P) begin
            next_s.wait_p = wr.data;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign osc_enable = power_on;
   assign light_active = (s.st == set_pkg::PH_LIGHT);
   assign prox_active = (s.st == set_pkg::PH_PROX);
   assign wait_active = (s.st == set_pkg::PH_WAIT);
   assign light_done = s.light_done;
   assign prox_done = s.prox_done;
   assign wait_done = s.wait_done;
   assign light_full_scale = s.full_scale;

   ////////////////////////////////////////////////////////////////////
   // phase length helpers for the checks below
   logic ph_start;
   int ph_len;
   int len_want;
   // a phase starts on a change or on a back to back repeat
   assign ph_start = s.st != next_s.st || next_s.light_done ||
      next_s.prox_done || next_s.wait_done;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ph_len <= 0;
         len_want <= 0;
      end else if (next_s.st == set_pkg::PH_IDLE) begin
         ph_len <= 0;
      end else if (!ph_start) begin
         ph_len <= ph_len + 1;
      end else begin
         ph_len <= 1;
         if (next_s.st == set_pkg::PH_LIGHT) begin
            len_want <= (int'(s.light_it) + 1) * LIGHT_TICK;
         end else if (next_s.st == set_pkg::PH_PROX) begin
            len_want <= (int'(s.prox_sp) + 1) * PROX_TICK;
         end else begin
            len_want <= (int'(s.wait_p) + 1) * LIGHT_TICK *
                        (long_wait_multiplier ? 12 : 1);
         end
      end
   end

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_power_off_idle: assert property (!power_on |=>
      s.st == set_pkg::PH_IDLE)
      else $error("phase running while powered off");
   chk_light_start: assert property (s.st == set_pkg::PH_IDLE &&
      power_on && light_en |=> s.st == set_pkg::PH_LIGHT)
      else $error("light phase did not start");
   chk_prox_gate: assert property ($rose(s.st == set_pkg::PH_PROX) |->
      $past(prox_en))
      else $error("proximity ran while disabled");
   chk_wait_gate: assert property ($rose(s.st == set_pkg::PH_WAIT) |->
      $past(wait_en))
      else $error("wait ran while disabled");
   chk_light_load: assert property ($rose(light_active) |->
      s.cnt == $past(s.light_it) && s.pre == 18'h00000)
      else $error("light counter not loaded");
   chk_light_length: assert property (s.light_done |->
      $past(ph_len) == $past(len_want))
      else $error("integration length wrong");
   chk_prox_length: assert property (s.prox_done |->
      $past(ph_len) == $past(len_want))
      else $error("proximity sample length wrong");
   chk_wait_length: assert property (s.wait_done |->
      $past(ph_len) == $past(len_want))
      else $error("wait length wrong");
   chk_scale_sat: assert property (s.light_it >= 8'h3F |=>
      light_full_scale == 16'hFFFF)
      else $error("full scale not saturated");
   chk_scale_step: assert property (s.light_it < 8'h3F |=>
      light_full_scale == {$past(s.light_it[5:0]) + 6'h01, 10'h000} - 16'h1)
      else $error("full scale step wrong");

   cov_light_done: cover property (light_done);
   cov_prox_done: cover property (prox_done);
   cov_long_wait: cover property (wait_done && s.lwm);
   cov_power_drop: cover property (light_active ##1 !power_on);
endmodule : set_timing

//--- bench/set_host_model.sv
`timescale 1ns/10ps
module set_host_model (
   input wire logic core_clk, // system clock
   input wire logic sda_oe, // device pulls data low
   output logic scl, // bus clock level
   output logic sda // resolved data line, pulled up
);
   logic sda_m;
   logic k;
   // pull-up: line is high unless someone pulls it low
   assign sda = sda_m & ~sda_oe;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic clk_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask : clk_n
   // data moves mid low, sampled mid high
   task automatic bit_io(input logic b, output logic r);
      clk_n(4);
      sda_m <= b;
      clk_n(4);
      scl <= 1'b1;
      clk_n(4);
      r = sda;
      clk_n(4);
      scl <= 1'b0;
   endtask : bit_io
   // st=1 start or repeated start, st=0 stop
   task automatic cond(input logic st);
      clk_n(4);
      sda_m <= st;
      clk_n(4);
      scl <= 1'b1;
      clk_n(8);
      sda_m <= ~st;
      clk_n(8);
      scl <= ~st;
   endtask : cond
   // msb first, ack is low on the ninth bit
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put_byte
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask : get_byte
   ////////////////////////////////////////////////////////////////////////
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                            output logic ok);
      cond(1'b1);
      put_byte({set_pkg::I2C_ADDR, 1'b0}, ok);
      put_byte(a, k);
      ok = ok & k;
      put_byte(d, k);
      ok = ok & k;
      cond(1'b0);
   endtask : write_reg
   // read at the kept pointer, nack on the only byte
   task automatic read_cur(output logic [7:0] d, output logic ok);
      cond(1'b1);
      put_byte({set_pkg::I2C_ADDR, 1'b1}, ok);
      get_byte(1'b1, d);
      cond(1'b0);
   endtask : read_cur
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
      logic k0;
      cond(1'b1);
      put_byte({set_pkg::I2C_ADDR, 1'b0}, k0);
      put_byte(a, k);
      read_cur(d, ok);
      ok = ok & k & k0;
   endtask : read_reg
endmodule : set_host_model

//--- bench/set_timing_tb.sv
`timescale 1ns/10ps
module set_timing_tb;
   localparam int LT = 4;
   localparam int PT = 3;
   logic core_clk, resetn, scl, sda, sda_out, sda_oe;
   logic long_wait_multiplier, osc_enable;
   logic light_active, prox_active, wait_active;
   logic light_done, prox_done, wait_done;
   logic [15:0] light_full_scale;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int got;
   logic ok, acc;
   logic [7:0] rd;

   set_timing #(.LIGHT_TICK(LT), .PROX_TICK(PT)) set_timing_i (
      .core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .long_wait_multiplier(long_wait_multiplier), .osc_enable(osc_enable),
      .light_active(light_active), .prox_active(prox_active),
      .wait_active(wait_active), .light_done(light_done),
      .prox_done(prox_done), .wait_done(wait_done),
      .light_full_scale(light_full_scale));
   set_host_model set_host_model_i (.core_clk(core_clk), .sda_oe(sda_oe),
      .scl(scl), .sda(sda));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         $display("mismatch at %0t: run too long", $time);
         final_report();
      end
   end
   task automatic check(input logic [15:0] g, input logic [15:0] e,
                        input string m);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      set_host_model_i.write_reg(a, d, ok);
      check(16'(ok), 16'h1, "write ack");
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      set_host_model_i.read_reg(a, rd, ok);
      check({7'h0, ok, rd}, {8'h1, e}, "read back");
   endtask : rdchk
   function automatic logic done_of(input int s);
      case (s)
         0: return light_done;
         1: return prox_done;
         default: return wait_done;
      endcase
   endfunction : done_of
   task automatic await_pulse(input int s);
      int n;
      n = 0;
      @(negedge core_clk);
      while (done_of(s) !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
   endtask : await_pulse
   // cycles between two done pulses, first two loops skipped
   task automatic measure(input int s, output int c);
      await_pulse(s);
      await_pulse(s);
      c = 0;
      do begin
         @(negedge core_clk);
         c++;
      end while (done_of(s) !== 1'b1 && c < 2000);
   endtask : measure
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(light_full_scale, 16'h03FF, "reset full scale");
      check({12'h0, osc_enable, light_active, prox_active, wait_active},
            16'h0, "reset idle");
      check(16'(sda_out), 16'h0, "open drain level");
      rdchk(8'h80, 8'h00);
      rdchk(8'h81, 8'h00);
      rdchk(8'h82, 8'h1F);
      rdchk(8'h83, 8'h00);
      rdchk(8'h84, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs();
      wr(8'h81, 8'h3F);
      check(light_full_scale, 16'hFFFF, "full scale 64");
      wr(8'h81, 8'h3E);
      check(light_full_scale, 16'hFBFF, "full scale 63");
      wr(8'h82, 8'hA5);
      rdchk(8'h81, 8'h3E);
      set_host_model_i.read_cur(rd, ok);
      check({7'h0, ok, rd}, 16'h01A5, "pointer kept");
      set_host_model_i.cond(1'b1);
      set_host_model_i.put_byte(8'h90, ok);
      set_host_model_i.cond(1'b0);
      check(16'(ok), 16'h0, "foreign address");
      $display("test registers done");
   endtask : t_regs
   task automatic t_light();
      wr(8'h81, 8'h01);
      wr(8'h80, 8'h03);
      check(16'(osc_enable), 16'h1, "power on");
      check(light_full_scale, 16'h07FF, "full scale 2");
      measure(0, got);
      check(16'(got), 16'(2 * LT), "light period");
      check({14'h0, prox_active, wait_active}, 16'h0, "only light");
      $display("test light done");
   endtask : t_light
   task automatic t_prox();
      wr(8'h82, 8'h02);
      wr(8'h80, 8'h05);
      measure(1, got);
      check(16'(got), 16'(3 * PT), "prox period");
      check({14'h0, light_active, wait_active}, 16'h0, "only prox");
      $display("test prox done");
   endtask : t_prox
   task automatic t_wait();
      wr(8'h83, 8'h02);
      rdchk(8'h83, 8'h02);
      wr(8'h80, 8'h0F);
      measure(2, got);
      check(16'(got), 16'(2 * LT + 3 * PT + 3 * LT), "cycle");
      @(posedge core_clk);
      long_wait_multiplier <= 1'b1;
      measure(2, got);
      check(16'(got), 16'(2 * LT + 3 * PT + 36 * LT), "long");
      @(posedge core_clk);
      long_wait_multiplier <= 1'b0;
      $display("test wait done");
   endtask : t_wait
   task automatic t_power();
      wr(8'h80, 8'h0E);
      acc = 1'b0;
      repeat (40) begin
         @(negedge core_clk);
         acc = acc | light_active | prox_active | wait_active | osc_enable
               | light_done | prox_done | wait_done;
      end
      check(16'(acc), 16'h0, "held idle");
      rdchk(8'h80, 8'h0E);
      $display("test power done");
   endtask : t_power
   ////////////////////////////////////////////////////////////////////////
   initial begin
      long_wait_multiplier = 1'b0;
      resetn = 1'b0;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(negedge core_clk);
      t_reset();
      t_regs();
      t_light();
      t_prox();
      t_wait();
      t_power();
      final_report();
   end
endmodule : set_timing_tb
